// *** design/atg_pkg.sv ***
// Purpose: Shared constants and types for the alert tone generator
// Assumes: APB register access, 32-bit data, one aligned word per register
// Notes:   All offsets, field positions and reset values live here

package atg_pkg;

   // =========================================================================
   // Register map
   // =========================================================================
   localparam logic [11:0] TONE_CTRL_OFFSET = 12'h000;  // Tone frequency control
   localparam logic [11:0] VOL_CTRL_OFFSET  = 12'h004;  // Volume modulation control
   localparam logic [11:0] STATUS_OFFSET    = 12'h008;  // Block status, read only

   localparam logic [7:0]  TONE_CTRL_RESET  = 8'h00;    // Tone off, output floats
   localparam logic [7:0]  VOL_CTRL_RESET   = 8'h00;    // No modulation

   // Status register bit positions
   localparam int STAT_PLL_POS   = 0;                   // Engaged loop seen
   localparam int STAT_TONE_POS  = 1;                   // Raw square wave level
   localparam int STAT_MOD_POS   = 2;                   // Modulating clock level
   localparam int STAT_OE_POS    = 3;                   // Alert pin driven

   // =========================================================================
   // Tone select codes
   // =========================================================================
   localparam logic [3:0] TONE_OFF   = 4'h0;            // High impedance
   localparam logic [3:0] TONE_GND   = 4'hF;            // Static logic 0

   // =========================================================================
   // Modulation selections
   // =========================================================================
   localparam logic [1:0] MDIV_1     = 2'h0;            // Base clock / 1
   localparam logic [1:0] MDIV_2     = 2'h1;            // Base clock / 2
   localparam logic [1:0] MDIV_4     = 2'h2;            // Base clock / 4
   localparam logic [1:0] MDIV_8X    = 2'h3;            // /8 or crystal
   localparam logic [4:0] PHASES_8   = 5'h08;           // 8-phase wrap
   localparam logic [4:0] PHASES_16  = 5'h10;           // 16-phase wrap
   localparam int         SYNC_BITS  = 4;               // Synchronised pins

   // =========================================================================
   // Carriers
   // =========================================================================
   typedef struct packed {
      logic [3:0] reserved;                             // Stored, no effect
      logic [3:0] tone_select_field;                    // Tone divisor code
   } atg_tone_ctrl_t;

   typedef struct packed {
      logic       phase_count_select;                   // 1 = 8 phases
      logic       modulation_source_select;             // 1 = clock direct
      logic       mod_divider_bit_hi;                   // Divider code high
      logic       mod_divider_bit_lo;                   // Divider code low
      logic [3:0] duty_cycle_field;                     // High counts
   } atg_vol_ctrl_t;

   // Half of each oscillator divisor, per tone code
   function automatic logic [5:0] atg_half_div(input logic [3:0] code);
      logic [5:0] h;
      h = 6'h00;
      case (code)
         4'h1:    h = 6'h10;   // /32
         4'h2:    h = 6'h04;   // /8
         4'h3:    h = 6'h08;   // /16
         4'h4:    h = 6'h03;   // /6
         4'h5:    h = 6'h06;   // /12
         4'h6:    h = 6'h0C;   // /24
         4'h7:    h = 6'h18;   // /48
         4'h8:    h = 6'h05;   // /10
         4'h9:    h = 6'h0A;   // /20
         4'hA:    h = 6'h14;   // /40
         4'hB:    h = 6'h28;   // /80
         4'hC:    h = 6'h07;   // /14
         4'hD:    h = 6'h0E;   // /28
         4'hE:    h = 6'h1C;   // /56
         default: h = 6'h00;
      endcase
      return h;
   endfunction

endpackage

// *** design/atg_tone_div.sv ***
// Purpose: Square wave divider counting oscillator edges
// Assumes: Oscillator rising edges arrive as one-cycle pulses
// Notes:   Output toggles every half-divisor edges

`timescale 1ns/10ps

module atg_tone_div
(
   input  wire logic       i_clock,    // System clock
   input  wire logic       i_resetn,   // Sync reset, active low
   input  wire logic       i_run,      // Divider allowed to count
   input  wire logic       i_osc_rise, // Oscillator rising edge pulse
   input  wire logic [5:0] i_half,     // Half divisor in osc edges
   output logic            o_tone      // Square wave level
);

   logic [5:0] count_q;
   logic       tone_q;

   // =========================================================================
   // Half period counter
   // =========================================================================
   always_ff @(posedge i_clock)
   begin
      if (!i_resetn || !i_run)
      begin
         count_q <= 6'h00;
      end
      else if (i_osc_rise)
      begin
         if (count_q + 6'h01 >= i_half)
         begin
            count_q <= 6'h00;
         end
         else
         begin
            count_q <= count_q + 6'h01;
         end
      end
   end

   // Toggle at the end of each half period
   always_ff @(posedge i_clock)
   begin
      if (!i_resetn || !i_run)
      begin
         tone_q <= 1'b0;
      end
      else if (i_osc_rise && (count_q + 6'h01 >= i_half))
      begin
         tone_q <= ~tone_q;
      end
   end

   assign o_tone = tone_q;

endmodule // atg_tone_div

// *** design/atg_top.sv ***
// Purpose: Alert tone generator with volume modulation, APB slave
// Assumes: Oscillator, base and crystal clocks sampled as plain pins
// Notes:   Alert pin is two signals: level, enable; no inout here

`timescale 1ns/10ps

module atg_top
(
   input  wire logic        I_CLOCK,       // 200 MHz system clock
   input  wire logic        I_RESETN,      // Sync reset, active low
   input  wire logic        I_PSEL,        // APB select
   input  wire logic        I_PENABLE,     // APB access phase
   input  wire logic        I_PWRITE,      // APB write
   input  wire logic [11:0] I_PADDR,       // APB byte address
   input  wire logic [31:0] I_PWDATA,      // APB write data
   input  wire logic [3:0]  I_PSTRB,       // APB byte strobes
   output logic      [31:0] O_PRDATA,      // APB read data
   output logic             O_PREADY,      // APB ready
   output logic             O_PSLVERR,     // APB error, unmapped
   input  wire logic        I_PLL_ENGAGED, // Loop engaged, async
   input  wire logic        I_OSC_CLK,     // Oscillator clock pin
   input  wire logic        I_BASE_CLK,    // Modulation base clock
   input  wire logic        I_XTAL_CLK,    // Crystal clock pin
   output logic             O_ALERT,       // Alert pin level
   output logic             O_ALERT_OE     // Alert pin drive enable
);

   // =========================================================================
   // Declarations
   // =========================================================================
   atg_pkg::atg_tone_ctrl_t tone_ctrl_q;
   atg_pkg::atg_vol_ctrl_t  vol_ctrl_q;

   logic [atg_pkg::SYNC_BITS-1:0] pin_raw;
   logic [atg_pkg::SYNC_BITS-1:0] sync1_q;
   logic [atg_pkg::SYNC_BITS-1:0] sync2_q;
   logic [atg_pkg::SYNC_BITS-1:0] prev_q;

   logic        pll_ok;
   logic        osc_rise;
   logic        base_rise;
   logic        base_lvl;
   logic        xtal_lvl;

   logic        pready_q;
   logic        pslverr_q;
   logic [31:0] prdata_q;
   logic        access;
   logic        wr_en;
   logic        mapped;
   logic [31:0] rd_mux;

   logic [2:0]  base_div_q;
   logic        high_modulation_clock;
   logic        high_mod_prev_q;
   logic        high_mod_rise;
   logic [3:0]  phase_q;
   logic [4:0]  phase_wrap;
   logic        duty_modulator_output;
   logic        volume_modulating_clock;
   logic        mod_en;
   logic        tone;
   logic [3:0]  sel;
   logic [1:0]  mdiv;

   logic        alert_d;
   logic        alert_oe_d;
   logic        alert_q;
   logic        alert_oe_q;

   // =========================================================================
   // Pin synchronisers
   // =========================================================================
   assign pin_raw = {I_XTAL_CLK, I_BASE_CLK, I_OSC_CLK, I_PLL_ENGAGED};

   // Two flops per pin, then an edge history flop
   genvar gi;
   generate
      for (gi = 0; gi < atg_pkg::SYNC_BITS; gi++)
      begin : g_sync
         always_ff @(posedge I_CLOCK)
         begin
            if (!I_RESETN)
            begin
               sync1_q[gi] <= 1'b0;
               sync2_q[gi] <= 1'b0;
               prev_q[gi]  <= 1'b0;
            end
            else
            begin
               sync1_q[gi] <= pin_raw[gi];
               sync2_q[gi] <= sync1_q[gi];
               prev_q[gi]  <= sync2_q[gi];
            end
         end
      end
   endgenerate

   // Clean levels and edges
   assign pll_ok    = sync2_q[0];
   assign osc_rise  = sync2_q[1] & ~prev_q[1];
   assign base_lvl  = sync2_q[2];
   assign base_rise = sync2_q[2] & ~prev_q[2];
   assign xtal_lvl  = sync2_q[3];

   // =========================================================================
   // APB slave
   // =========================================================================
   assign access = I_PSEL & I_PENABLE;
   assign wr_en  = access & pready_q & I_PWRITE & I_PSTRB[0];
   assign mapped = (I_PADDR == atg_pkg::TONE_CTRL_OFFSET) ||
                   (I_PADDR == atg_pkg::VOL_CTRL_OFFSET)  ||
                   (I_PADDR == atg_pkg::STATUS_OFFSET);

   // Read data selection
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      case (I_PADDR)
         atg_pkg::TONE_CTRL_OFFSET: rd_mux[7:0] = tone_ctrl_q;
         atg_pkg::VOL_CTRL_OFFSET:  rd_mux[7:0] = vol_ctrl_q;
         atg_pkg::STATUS_OFFSET:
         begin
            rd_mux[atg_pkg::STAT_PLL_POS]  = pll_ok;
            rd_mux[atg_pkg::STAT_TONE_POS] = tone;
            rd_mux[atg_pkg::STAT_MOD_POS]  = volume_modulating_clock;
            rd_mux[atg_pkg::STAT_OE_POS]   = alert_oe_q;
         end
         default:                   rd_mux = 32'h0000_0000;
      endcase
   end

   // One wait state, ready for a single cycle
   always_ff @(posedge I_CLOCK)
   begin
      if (!I_RESETN)
      begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end
      else if (access && !pready_q)
      begin
         pready_q  <= 1'b1;
         pslverr_q <= ~mapped;
         prdata_q  <= I_PWRITE ? 32'h0000_0000 : rd_mux;
      end
      else
      begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end
   end

   // Tone control register
   always_ff @(posedge I_CLOCK)
   begin
      if (!I_RESETN)
      begin
         tone_ctrl_q <= atg_pkg::TONE_CTRL_RESET;
      end
      else if (wr_en && I_PADDR == atg_pkg::TONE_CTRL_OFFSET)
      begin
         tone_ctrl_q <= I_PWDATA[7:0];
      end
   end

   // Volume modulation control register
   always_ff @(posedge I_CLOCK)
   begin
      if (!I_RESETN)
      begin
         vol_ctrl_q <= atg_pkg::VOL_CTRL_RESET;
      end
      else if (wr_en && I_PADDR == atg_pkg::VOL_CTRL_OFFSET)
      begin
         vol_ctrl_q <= I_PWDATA[7:0];
      end
   end

   assign O_PREADY  = pready_q;
   assign O_PSLVERR = pslverr_q;
   assign O_PRDATA  = prdata_q;

   // =========================================================================
   // Tone square wave
   // =========================================================================
   assign sel = tone_ctrl_q.tone_select_field;

   atg_tone_div u_tone_div
   (
      .i_clock    (I_CLOCK),
      .i_resetn   (I_RESETN),
      .i_run      (pll_ok && sel != atg_pkg::TONE_OFF && sel != atg_pkg::TONE_GND),
      .i_osc_rise (osc_rise),
      .i_half     (atg_pkg::atg_half_div(sel)),
      .o_tone     (tone)
   );

   // =========================================================================
   // High modulation clock
   // =========================================================================
   assign mdiv = {vol_ctrl_q.mod_divider_bit_hi, vol_ctrl_q.mod_divider_bit_lo};

   // Binary count of base clock edges
   always_ff @(posedge I_CLOCK)
   begin
      if (!I_RESETN || !pll_ok)
      begin
         base_div_q <= 3'h0;
      end
      else if (base_rise)
      begin
         base_div_q <= base_div_q + 3'h1;
      end
   end

   // Divider and crystal selection
   always_comb
   begin
      high_modulation_clock = base_lvl;
      case (mdiv)
         atg_pkg::MDIV_1: high_modulation_clock = base_lvl;
         atg_pkg::MDIV_2: high_modulation_clock = base_div_q[0];
         atg_pkg::MDIV_4: high_modulation_clock = base_div_q[1];
         atg_pkg::MDIV_8X:
         begin
            high_modulation_clock = vol_ctrl_q.modulation_source_select ? xtal_lvl : base_div_q[2];
         end
         default:         high_modulation_clock = base_lvl;
      endcase
   end

   // Edge history of the selected clock
   always_ff @(posedge I_CLOCK)
   begin
      if (!I_RESETN)
      begin
         high_mod_prev_q <= 1'b0;
      end
      else
      begin
         high_mod_prev_q <= high_modulation_clock;
      end
   end

   assign high_mod_rise = high_modulation_clock & ~high_mod_prev_q;

   // =========================================================================
   // Duty cycle modulator
   // =========================================================================
   // phase count wrap
   assign phase_wrap = vol_ctrl_q.phase_count_select ? atg_pkg::PHASES_8
                                                     : atg_pkg::PHASES_16;

   // Phase counter on modulation clock edges
   always_ff @(posedge I_CLOCK)
   begin
      if (!I_RESETN || !pll_ok)
      begin
         phase_q <= 4'h0;
      end
      else if (high_mod_rise)
      begin
         if ({1'b0, phase_q} + 5'h01 >= phase_wrap)
         begin
            phase_q <= 4'h0;
         end
         else
         begin
            phase_q <= phase_q + 4'h1;
         end
      end
   end

   assign duty_modulator_output = (phase_q < vol_ctrl_q.duty_cycle_field);

   assign volume_modulating_clock = vol_ctrl_q.modulation_source_select ? high_modulation_clock
                                                                        : duty_modulator_output;

   assign mod_en = vol_ctrl_q.modulation_source_select ||
                   (vol_ctrl_q.duty_cycle_field != 4'h0);

   // =========================================================================
   // Alert pin
   // =========================================================================
   always_comb
   begin
      alert_d    = 1'b0;
      alert_oe_d = 1'b0;
      if (!pll_ok)
      begin
         alert_d    = 1'b0;
         alert_oe_d = 1'b0;
      end
      else if (sel == atg_pkg::TONE_OFF)
      begin
         alert_d    = 1'b0;
         alert_oe_d = 1'b0;
      end
      else if (sel == atg_pkg::TONE_GND)
      begin
         alert_d    = 1'b0;
         alert_oe_d = 1'b1;
      end
      else
      begin
         alert_d    = mod_en ? (tone & volume_modulating_clock) : tone;
         alert_oe_d = 1'b1;
      end
   end

   // Output flops
   always_ff @(posedge I_CLOCK)
   begin
      if (!I_RESETN)
      begin
         alert_q    <= 1'b0;
         alert_oe_q <= 1'b0;
      end
      else
      begin
         alert_q    <= alert_d;
         alert_oe_q <= alert_oe_d;
      end
   end

   assign O_ALERT    = alert_q;
   assign O_ALERT_OE = alert_oe_q;

endmodule // atg_top

// *** test/atg_props.sv ***
// Purpose: Port assertions for the alert tone generator
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to atg_top below
`timescale 1ns/10ps

module atg_props
(
   input wire logic        I_CLOCK,       // Clock
   input wire logic        I_RESETN,      // Reset, active low
   input wire logic        I_PSEL,        // APB select
   input wire logic        I_PENABLE,     // APB access
   input wire logic        I_PWRITE,      // APB write
   input wire logic [11:0] I_PADDR,       // APB address
   input wire logic [31:0] I_PWDATA,      // APB write data
   input wire logic [3:0]  I_PSTRB,       // APB strobes
   input wire logic [31:0] O_PRDATA,      // APB read data
   input wire logic        O_PREADY,      // APB ready
   input wire logic        O_PSLVERR,     // APB error
   input wire logic        I_PLL_ENGAGED, // Loop engaged
   input wire logic        O_ALERT,       // Alert level
   input wire logic        O_ALERT_OE     // Alert enable
);
   // =========================================================================
   // Sequences
   // =========================================================================
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (!I_RESETN);

   // Completed write of a tone code
   sequence tone_wr(logic [3:0] v);
      I_PSEL && I_PENABLE && I_PWRITE && O_PREADY && I_PSTRB[0] &&
      I_PADDR == atg_pkg::TONE_CTRL_OFFSET && I_PWDATA[3:0] == v;
   endsequence

   // Access phase still waiting
   sequence access_wait;
      I_PSEL && I_PENABLE && !O_PREADY;
   endsequence

   // =========================================================================
   // Assertions
   // =========================================================================
   chk_ready_wait: assert property (access_wait |=> O_PREADY)
      else $error("ready missing after wait state");
   chk_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
      else $error("ready longer than one cycle");
   chk_idle_quiet: assert property (!I_PSEL |=> !O_PREADY)
      else $error("ready without select");
   chk_err_paired: assert property (O_PSLVERR |-> O_PREADY && (I_PWRITE || O_PRDATA == 32'h0))
      else $error("error without ready or with data");
   chk_reset_float: assert property (disable iff (1'b0) !I_RESETN |=> !O_ALERT_OE && !O_ALERT)
      else $error("alert driven after reset");
   chk_pll_float: assert property (!I_PLL_ENGAGED [*6] |=> !O_ALERT_OE)
      else $error("alert driven with loop off");
   chk_off_float: assert property (tone_wr(4'h0) |-> ##[1:4] !O_ALERT_OE)
      else $error("alert still driven after code zero");
   chk_gnd_static: assert property (tone_wr(4'hF) ##1 I_PLL_ENGAGED [*6] |-> O_ALERT_OE && !O_ALERT)
      else $error("alert not held low");
endmodule // atg_props

bind atg_top atg_props atg_props_inst (.I_CLOCK, .I_RESETN, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR,
   .I_PWDATA, .I_PSTRB, .O_PRDATA, .O_PREADY, .O_PSLVERR, .I_PLL_ENGAGED, .O_ALERT, .O_ALERT_OE);

// *** test/atg_transducer.sv ***
// Purpose: Transducer model on the alert pin
// Assumes: Pin has no pull, floats when not driven
// Notes:   Counts high cycles and rising edges
`timescale 1ns/10ps

module atg_transducer
(
   input  wire logic        i_clock, // Clock
   input  wire logic        i_alert, // Alert level
   input  wire logic        i_oe,    // Alert enable
   input  wire logic        i_clear, // Clear counters
   output logic             o_pin,   // Resolved pin
   output logic      [15:0] o_highs, // High cycles
   output logic      [15:0] o_rises  // Rising edges
);
   logic last_q = 1'b0;

   // Floating pin toggles each cycle
   assign o_pin = i_oe ? i_alert : ~last_q;

   // Remember last pin level
   always_ff @(posedge i_clock)
      last_q <= o_pin;

   // Count while driven
   always_ff @(posedge i_clock)
      if (i_clear)
      begin
         o_highs <= 16'h0000;
         o_rises <= 16'h0000;
      end
      else if (i_oe)
      begin
         o_highs <= o_highs + 16'(i_alert);
         o_rises <= o_rises + 16'(i_alert & ~last_q);
      end
endmodule // atg_transducer

// *** test/test_alert_tone_generator.sv ***
// Purpose: Self-checking bench for the alert tone generator
// Assumes: Oscillator period 16 cycles, base 4, crystal 10
// Notes:   Counts from the transducer model
`timescale 1ns/10ps

module test_alert_tone_generator;
   // =========================================================================
   // Signals
   // =========================================================================
   logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        pll = 1'b0, osc = 1'b0, base = 1'b0, xtal = 1'b0, clr = 1'b0, e;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r, rv;
   logic [3:0]  pstrb = 4'h0;
   logic        pready, pslverr, alert, oe, pin;
   logic [15:0] highs, rises;
   int          err_count = 0, n_checks = 0, seed = 32'h0943, cyc = 0, i, n;
   integer      hi, ri;
   logic [7:0]  mv[14] = '{8'h80, 8'h81, 8'h85, 8'h88, 8'h0F, 8'h03, 8'h40, 8'h50, 8'h60, 8'h70,
                          8'h84, 8'h94, 8'hA4, 8'hB4};
   int          mx[14] = '{640, 80, 400, 640, 600, 120, 160, 80, 40, 64, 20, 10, 5, 2};

   // Clock and pin clocks
   initial forever #2.5 clk = ~clk;
   always @(posedge clk)
   begin
      cyc  <= cyc + 1;
      osc  <= cyc[3];
      base <= cyc[1];
      xtal <= (cyc % 10) < 5;
   end

   atg_top atg_top_inst (.I_CLOCK(clk), .I_RESETN(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
      .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PRDATA(prdata),
      .O_PREADY(pready), .O_PSLVERR(pslverr), .I_PLL_ENGAGED(pll), .I_OSC_CLK(osc),
      .I_BASE_CLK(base), .I_XTAL_CLK(xtal), .O_ALERT(alert), .O_ALERT_OE(oe));
   atg_transducer atg_transducer_inst (.i_clock(clk), .i_alert(alert), .i_oe(oe), .i_clear(clr),
      .o_pin(pin), .o_highs(highs), .o_rises(rises));

   // =========================================================================
   // Tasks
   // =========================================================================
   task give_verdict;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
      end
   endtask

   task near(input integer got, input int exp, input int tol);
      check((got - exp <= tol && exp - got <= tol) ? exp : got, exp);
   endtask

   task bound(input int k, input int lim);
      if (k >= lim)
      begin
         err_count++;
         $display("unexpected timeout at %0t: count %0h limit %0h", $time, k, lim);
         give_verdict;
      end
   endtask

   // One APB transfer, result in r and e
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      int k;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      pstrb  <= s;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (pready !== 1'b1 && k < 50);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
      bound(k, 50);
   endtask

   // Length of a full half period
   task meas;
      logic v;
      for (int j = 0; j < 2; j++)
      begin
         v = pin;
         n = 0;
         while (pin === v && n < 3000)
         begin
            @(posedge clk);
            n++;
         end
      end
      bound(n, 3000);
   endtask

   // One tone period of pin counts
   task win;
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (1280) @(posedge clk);
      hi = highs;
      ri = rises;
   endtask

   function automatic int div_of(input int c);
      int t[15] = '{0, 32, 8, 16, 6, 12, 24, 48, 10, 20, 40, 80, 14, 28, 56};
      return t[c];
   endfunction

   // =========================================================================
   // Sequence
   // =========================================================================
   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      pll   <= 1'b1;
      repeat (3) @(posedge clk);
      apb(1'b0, atg_pkg::TONE_CTRL_OFFSET, 32'h0, 4'hF);
      check(r, 32'h0);
      check({31'h0, oe}, 32'h0);
      apb(1'b0, atg_pkg::VOL_CTRL_OFFSET, 32'h0, 4'hF);
      check(r, 32'h0);
      apb(1'b0, 12'h00C, 32'h0, 4'hF);
      check({31'h0, e}, 32'h1);
      apb(1'b1, atg_pkg::TONE_CTRL_OFFSET, 32'h0F, 4'hE);
      apb(1'b0, atg_pkg::TONE_CTRL_OFFSET, 32'h0, 4'hF);
      check(r, 32'h0);
      $display("test registers done");
      for (i = 1; i < 15; i++)
      begin
         rv = $random(seed);
         apb(1'b1, atg_pkg::TONE_CTRL_OFFSET, {24'h0, rv[7:4], i[3:0]}, 4'hF);
         apb(1'b0, atg_pkg::TONE_CTRL_OFFSET, 32'h0, 4'hF);
         check(r, {24'h0, rv[7:4], i[3:0]});
         meas;
         near(n, div_of(i) * 8, 0);
      end
      $display("test divisors done");
      apb(1'b1, atg_pkg::TONE_CTRL_OFFSET, 32'h0F, 4'hF);
      win;
      check({31'h0, oe}, 32'h1);
      check(hi, 0);
      apb(1'b0, atg_pkg::STATUS_OFFSET, 32'h0, 4'hF);
      check(r & 32'h9, 32'h9);
      pll <= 1'b0;
      apb(1'b1, atg_pkg::TONE_CTRL_OFFSET, 32'h01, 4'hF);
      repeat (8) @(posedge clk);
      check({31'h0, oe}, 32'h0);
      pll <= 1'b1;
      $display("test static modes done");
      apb(1'b1, atg_pkg::TONE_CTRL_OFFSET, 32'h0B, 4'hF);
      for (i = 0; i < 14; i++)
      begin
         apb(1'b1, atg_pkg::VOL_CTRL_OFFSET, {24'h0, mv[i]}, 4'hF);
         win;
         if (i < 6)
            near(hi, mx[i], 8);
         else
            near(ri, mx[i], 2);
      end
      $display("test modulation done");
      apb(1'b1, atg_pkg::VOL_CTRL_OFFSET, 32'h0, 4'hF);
      apb(1'b1, atg_pkg::TONE_CTRL_OFFSET, 32'h0, 4'hF);
      repeat (4) @(posedge clk);
      check({31'h0, oe}, 32'h0);
      $display("test off done");
      give_verdict;
   end

   // Hang guard
   initial
   begin
      repeat (60000) @(posedge clk);
      bound(1, 1);
   end
endmodule // test_alert_tone_generator
